// *** rtl/pmcd_pkg.sv ***
// Constants, types and helpers shared by the power mode and clock logic
package pmcd_pkg;

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PM_FULL_ON    = 3'h0,
        PM_ACTIVE     = 3'h1,
        PM_SLEEP      = 3'h2,
        PM_DEEP_SLEEP = 3'h3,
        PM_HIBERNATE  = 3'h4,
        PM_PROC_RESET = 3'h5
    } pmcd_mode_t;

    // ------------------------------------------------------------
    // Wake causes
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        WK_NONE  = 3'h0,
        WK_RESET = 3'h1,
        WK_RTC   = 3'h2,
        WK_CAN   = 3'h3,
        WK_GP    = 3'h4,
        WK_IRQ   = 3'h5
    } pmcd_wake_t;

    // ------------------------------------------------------------
    // Multiplier, in half steps: code 1 is 0.5x, code 128 is 64x
    // ------------------------------------------------------------
    localparam int MULT_W = 8;
    localparam logic [MULT_W-1:0] MULT_MIN = 8'h01;
    localparam logic [MULT_W-1:0] MULT_MAX = 8'h80;
    localparam logic [MULT_W-1:0] MULT_RESET = 8'h14;

    // ------------------------------------------------------------
    // Divider select fields
    // ------------------------------------------------------------
    localparam int PDIV_W = 4;
    localparam int CDIV_W = 2;
    localparam logic [PDIV_W-1:0] PDIV_ILLEGAL = 4'h0;
    localparam logic [PDIV_W-1:0] PDIV_RESET = 4'h5;
    localparam logic [CDIV_W-1:0] CDIV_RESET = 2'h0;
    localparam logic [PDIV_W-1:0] RATIO_ONE = 4'h1;

    // ------------------------------------------------------------
    // Regulator control
    // ------------------------------------------------------------
    localparam int REGULATOR_FIELD_A_W = 2;
    localparam int LVL_W = 4;
    localparam int MV_W = 11;
    localparam logic [REGULATOR_FIELD_A_W-1:0] REGULATOR_FIELD_A_OFF = 2'h0;
    localparam logic [REGULATOR_FIELD_A_W-1:0] REGULATOR_FIELD_A_RESET = 2'h3;
    localparam logic [LVL_W-1:0] LVL_RESET = 4'h9;
    localparam logic [MV_W-1:0] VR_BASE_MV = 11'h320;
    localparam logic [MV_W-1:0] VR_STEP_MV = 11'h032;
    localparam logic [MV_W-1:0] VR_ZERO_MV = 11'h000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int PROC_RST_NS = 1000;
    localparam int PROC_RST_CYC =
        (PROC_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_CNT_W = 6;

    // ------------------------------------------------------------
    // Pin synchroniser layout
    // ------------------------------------------------------------
    localparam int SYN_W = 5;
    localparam int SYN_RST = 4;
    localparam int SYN_RTC = 3;
    localparam int SYN_CAN = 2;
    localparam int SYN_GP = 1;
    localparam int SYN_IRQ = 0;
    localparam logic [SYN_W-1:0] SYN_RESET_VAL = 5'h10;

    // Core divide code to ratio 1, 2, 4, 8
    function automatic logic [PDIV_W-1:0] core_ratio(
        input logic [CDIV_W-1:0] sel);
        core_ratio = RATIO_ONE << sel;
    endfunction : core_ratio

    // Voltage target for a level code
    function automatic logic [MV_W-1:0] level_mv(
        input logic [LVL_W-1:0] lvl);
        level_mv = VR_BASE_MV + MV_W'(lvl) * VR_STEP_MV;
    endfunction : level_mv

endpackage : pmcd_pkg

// *** rtl/pmcd_clk_div.sv ***
// Glitch-free divider producing a one-cycle clock enable
`timescale 1ns/1ns
module pmcd_clk_div
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Control
    input wire logic run_i,
    input wire logic bypass_i,
    input wire logic [pmcd_pkg::PDIV_W-1:0] ratio_i,
    // Derived enable
    output logic tick_o
);

    logic [pmcd_pkg::PDIV_W-1:0] cnt_reg;
    logic [pmcd_pkg::PDIV_W-1:0] ratio_reg;
    logic tick_reg;
    wire logic period_end;
    wire logic boundary;

    assign period_end = (cnt_reg == ratio_reg - pmcd_pkg::RATIO_ONE);
    // Ratio changes at the end of a whole period, or while stopped or bypassed
    assign boundary = period_end | ~run_i | bypass_i;
    assign tick_o = tick_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            cnt_reg <= '0;
            ratio_reg <= pmcd_pkg::RATIO_ONE;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= run_i & (bypass_i | period_end);
            if (boundary)
            begin
                cnt_reg <= '0;
                ratio_reg <= ratio_i;
            end
            else
            begin
                cnt_reg <= cnt_reg + pmcd_pkg::RATIO_ONE;
            end
        end
    end

endmodule : pmcd_clk_div

// *** rtl/pmcd_top.sv ***
// Power mode controller with PLL multiplier and clock dividers
`timescale 1ns/1ns
module pmcd_top
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Pins and wake events from outside the clock domain
    input wire logic ext_resetn_i,
    input wire logic rtc_wake_i,
    input wire logic can_wake_i,
    input wire logic gp_wake_i,
    input wire logic irq_wake_i,
    // Mode request
    input wire logic mode_req_i,
    input wire logic [2:0] mode_sel_i,
    input wire logic pll_bypass_i,
    // Regulator control write
    input wire logic vr_wr_i,
    input wire logic [pmcd_pkg::REGULATOR_FIELD_A_W-1:0] regulator_field_a_i,
    input wire logic [pmcd_pkg::LVL_W-1:0] vr_level_i,
    // Multiplier and divider writes
    input wire logic pll_wr_i,
    input wire logic [pmcd_pkg::MULT_W-1:0] pll_mult_i,
    input wire logic div_wr_i,
    input wire logic [pmcd_pkg::PDIV_W-1:0] periph_div_select_i,
    input wire logic [pmcd_pkg::CDIV_W-1:0] core_div_select_i,
    // Mode status
    output logic [2:0] mode_o,
    output logic [2:0] wake_cause_o,
    output logic proc_reset_o,
    output logic boot_start_o,
    output logic cfg_err_o,
    // Clock enables
    output logic core_clk_en_o,
    output logic periph_clk_en_o,
    // PLL and divider state
    output logic pll_enable_o,
    output logic pll_bypassed_o,
    output logic [pmcd_pkg::MULT_W-1:0] pll_mult_o,
    output logic [pmcd_pkg::MULT_W-1:0] pll_mult_pend_o,
    output logic [pmcd_pkg::PDIV_W-1:0] periph_div_select_o,
    output logic [pmcd_pkg::CDIV_W-1:0] core_div_select_o,
    // Regulator and pins
    output logic regulator_on_o,
    output logic [pmcd_pkg::REGULATOR_FIELD_A_W-1:0] regulator_field_a_o,
    output logic [pmcd_pkg::MV_W-1:0] core_supply_mv_o,
    output logic pin_hiz_o,
    output logic async_block_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pmcd_pkg::pmcd_mode_t mode_reg;
    pmcd_pkg::pmcd_mode_t mode_next;
    pmcd_pkg::pmcd_wake_t cause_next;
    logic [pmcd_pkg::SYN_W-1:0] syn1_reg;
    logic [pmcd_pkg::SYN_W-1:0] syn2_reg;
    logic [pmcd_pkg::RST_CNT_W-1:0] rst_cnt_reg;
    logic [2:0] cause_reg;
    logic [pmcd_pkg::MULT_W-1:0] mult_reg;
    logic [pmcd_pkg::MULT_W-1:0] mult_pend_reg;
    logic [pmcd_pkg::PDIV_W-1:0] pdiv_reg;
    logic [pmcd_pkg::CDIV_W-1:0] cdiv_reg;
    logic [pmcd_pkg::REGULATOR_FIELD_A_W-1:0] regulator_field_a_reg;
    logic [pmcd_pkg::LVL_W-1:0] lvl_reg;
    logic [pmcd_pkg::MV_W-1:0] mv_reg;
    logic boot_reg;
    logic err_reg;
    logic preset_reg;
    logic pll_en_reg;
    logic byp_reg;
    logic reg_on_reg;
    logic hiz_reg;
    logic blk_reg;

    wire logic rst_pin;
    wire logic rtc_ev;
    wire logic can_ev;
    wire logic gp_ev;
    wire logic irq_ev;
    wire logic running;
    wire logic rst_done;
    wire logic req_legal;
    wire logic vr_off_req;
    wire logic mult_legal;
    wire logic pdiv_legal;
    wire logic cfg_bad;
    wire logic enter_full;
    wire logic core_run;
    wire logic periph_run;
    wire logic div_bypass;
    wire logic [pmcd_pkg::PDIV_W-1:0] core_ratio_w;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            syn1_reg <= pmcd_pkg::SYN_RESET_VAL;
            syn2_reg <= pmcd_pkg::SYN_RESET_VAL;
        end
        else
        begin
            syn1_reg <= {ext_resetn_i, rtc_wake_i, can_wake_i,
                         gp_wake_i, irq_wake_i};
            syn2_reg <= syn1_reg;
        end
    end

    assign rst_pin = ~syn2_reg[pmcd_pkg::SYN_RST];
    assign rtc_ev = syn2_reg[pmcd_pkg::SYN_RTC];
    assign can_ev = syn2_reg[pmcd_pkg::SYN_CAN];
    assign gp_ev = syn2_reg[pmcd_pkg::SYN_GP];
    assign irq_ev = syn2_reg[pmcd_pkg::SYN_IRQ];

    // ------------------------------------------------------------
    // Request decoding
    // ------------------------------------------------------------
    assign running = (mode_reg == pmcd_pkg::PM_FULL_ON) |
                     (mode_reg == pmcd_pkg::PM_ACTIVE);
    assign req_legal = mode_req_i & running &
                       (mode_sel_i <= 3'(pmcd_pkg::PM_DEEP_SLEEP));
    assign vr_off_req = vr_wr_i & running &
                        (regulator_field_a_i == pmcd_pkg::REGULATOR_FIELD_A_OFF);
    assign mult_legal = (pll_mult_i >= pmcd_pkg::MULT_MIN) &
                        (pll_mult_i <= pmcd_pkg::MULT_MAX);
    assign pdiv_legal = (periph_div_select_i != pmcd_pkg::PDIV_ILLEGAL);
    assign cfg_bad = (mode_req_i & ~req_legal) |
                     (pll_wr_i & ~(mult_legal & running)) |
                     (div_wr_i & ~(pdiv_legal & running));
    assign rst_done = ~rst_pin &
        (rst_cnt_reg == pmcd_pkg::RST_CNT_W'(pmcd_pkg::PROC_RST_CYC - 1));
    assign enter_full = (mode_next == pmcd_pkg::PM_FULL_ON) &
                        (mode_reg != pmcd_pkg::PM_FULL_ON);

    // ------------------------------------------------------------
    // Mode next state
    // ------------------------------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        cause_next = pmcd_pkg::WK_NONE;
        case (mode_reg)
            pmcd_pkg::PM_FULL_ON,
            pmcd_pkg::PM_ACTIVE:
            begin
                if (rst_pin)
                begin
                    mode_next = pmcd_pkg::PM_PROC_RESET;
                    cause_next = pmcd_pkg::WK_RESET;
                end
                else if (vr_off_req)
                    mode_next = pmcd_pkg::PM_HIBERNATE;
                else if (req_legal)
                    mode_next = pmcd_pkg::pmcd_mode_t'(mode_sel_i);
            end
            pmcd_pkg::PM_SLEEP:
            begin
                if (rst_pin)
                begin
                    mode_next = pmcd_pkg::PM_PROC_RESET;
                    cause_next = pmcd_pkg::WK_RESET;
                end
                else if (irq_ev | rtc_ev | can_ev | gp_ev)
                begin
                    mode_next = pll_bypass_i ? pmcd_pkg::PM_ACTIVE
                                             : pmcd_pkg::PM_FULL_ON;
                    cause_next = rtc_ev ? pmcd_pkg::WK_RTC
                                        : pmcd_pkg::WK_IRQ;
                end
            end
            pmcd_pkg::PM_DEEP_SLEEP:
            begin
                if (rst_pin)
                begin
                    mode_next = pmcd_pkg::PM_PROC_RESET;
                    cause_next = pmcd_pkg::WK_RESET;
                end
                else if (rtc_ev)
                begin
                    mode_next = pmcd_pkg::PM_ACTIVE;
                    cause_next = pmcd_pkg::WK_RTC;
                end
            end
            pmcd_pkg::PM_HIBERNATE:
            begin
                if (rst_pin | rtc_ev | can_ev | gp_ev)
                    mode_next = pmcd_pkg::PM_PROC_RESET;
                if (rst_pin)
                    cause_next = pmcd_pkg::WK_RESET;
                else if (rtc_ev)
                    cause_next = pmcd_pkg::WK_RTC;
                else if (can_ev)
                    cause_next = pmcd_pkg::WK_CAN;
                else if (gp_ev)
                    cause_next = pmcd_pkg::WK_GP;
            end
            pmcd_pkg::PM_PROC_RESET:
            begin
                if (rst_done)
                    mode_next = pmcd_pkg::PM_FULL_ON;
            end
            default:
                mode_next = pmcd_pkg::PM_FULL_ON;
        endcase
    end

    // ------------------------------------------------------------
    // Mode register and reset counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            mode_reg <= pmcd_pkg::PM_FULL_ON;
            cause_reg <= 3'(pmcd_pkg::WK_NONE);
            rst_cnt_reg <= '0;
        end
        else
        begin
            mode_reg <= mode_next;
            if (cause_next != pmcd_pkg::WK_NONE)
                cause_reg <= 3'(cause_next);
            if (mode_reg != pmcd_pkg::PM_PROC_RESET || rst_pin)
                rst_cnt_reg <= '0;
            else
                rst_cnt_reg <= rst_cnt_reg + pmcd_pkg::RST_CNT_W'(1'b1);
        end
    end

    // ------------------------------------------------------------
    // Multiplier and divider settings
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i || mode_reg == pmcd_pkg::PM_PROC_RESET)
        begin
            mult_reg <= pmcd_pkg::MULT_RESET;
            mult_pend_reg <= pmcd_pkg::MULT_RESET;
            pdiv_reg <= pmcd_pkg::PDIV_RESET;
            cdiv_reg <= pmcd_pkg::CDIV_RESET;
        end
        else
        begin
            if (pll_wr_i && mult_legal && running)
                mult_pend_reg <= pll_mult_i;
            if (enter_full)
                mult_reg <= mult_pend_reg;
            if (div_wr_i && pdiv_legal && running)
            begin
                pdiv_reg <= periph_div_select_i;
                cdiv_reg <= core_div_select_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Regulator control
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i || mode_reg == pmcd_pkg::PM_PROC_RESET)
        begin
            regulator_field_a_reg <= pmcd_pkg::REGULATOR_FIELD_A_RESET;
            lvl_reg <= pmcd_pkg::LVL_RESET;
        end
        else if (vr_wr_i && running)
        begin
            regulator_field_a_reg <= regulator_field_a_i;
            lvl_reg <= vr_level_i;
        end
    end

    // ------------------------------------------------------------
    // Derived clock enables
    // ------------------------------------------------------------
    // core stopped outside running modes, peripheral also runs in sleep
    assign core_run = (mode_reg == pmcd_pkg::PM_FULL_ON) |
                      (mode_reg == pmcd_pkg::PM_ACTIVE);
    assign periph_run = core_run | (mode_reg == pmcd_pkg::PM_SLEEP);
    assign div_bypass = (mode_reg == pmcd_pkg::PM_ACTIVE);
    assign core_ratio_w = pmcd_pkg::core_ratio(cdiv_reg);

    pmcd_clk_div u_core_div
    (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .run_i(core_run),
        .bypass_i(div_bypass),
        .ratio_i(core_ratio_w),
        .tick_o(core_clk_en_o)
    );

    pmcd_clk_div u_periph_div
    (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .run_i(periph_run),
        .bypass_i(div_bypass),
        .ratio_i(pdiv_reg),
        .tick_o(periph_clk_en_o)
    );

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            boot_reg <= 1'b0;
            err_reg <= 1'b0;
            preset_reg <= 1'b0;
            pll_en_reg <= 1'b1;
            byp_reg <= 1'b0;
            reg_on_reg <= 1'b1;
            hiz_reg <= 1'b0;
            blk_reg <= 1'b0;
            mv_reg <= pmcd_pkg::level_mv(pmcd_pkg::LVL_RESET);
        end
        else
        begin
            boot_reg <= (mode_reg == pmcd_pkg::PM_PROC_RESET) & rst_done;
            err_reg <= cfg_bad;
            preset_reg <= (mode_next == pmcd_pkg::PM_PROC_RESET);
            pll_en_reg <= (mode_next != pmcd_pkg::PM_DEEP_SLEEP) &
                          (mode_next != pmcd_pkg::PM_HIBERNATE);
            byp_reg <= (mode_next == pmcd_pkg::PM_ACTIVE);
            reg_on_reg <= (mode_next != pmcd_pkg::PM_HIBERNATE);
            hiz_reg <= (mode_next == pmcd_pkg::PM_HIBERNATE);
            blk_reg <= (mode_next == pmcd_pkg::PM_DEEP_SLEEP);
            if (mode_next == pmcd_pkg::PM_HIBERNATE)
                mv_reg <= pmcd_pkg::VR_ZERO_MV;
            else
                mv_reg <= pmcd_pkg::level_mv(lvl_reg);
        end
    end

    assign mode_o = 3'(mode_reg);
    assign wake_cause_o = cause_reg;
    assign proc_reset_o = preset_reg;
    assign boot_start_o = boot_reg;
    assign cfg_err_o = err_reg;
    assign pll_enable_o = pll_en_reg;
    assign pll_bypassed_o = byp_reg;
    assign pll_mult_o = mult_reg;
    assign pll_mult_pend_o = mult_pend_reg;
    assign periph_div_select_o = pdiv_reg;
    assign core_div_select_o = cdiv_reg;
    assign regulator_on_o = reg_on_reg;
    assign regulator_field_a_o = regulator_field_a_reg;
    assign core_supply_mv_o = mv_reg;
    assign pin_hiz_o = hiz_reg;
    assign async_block_o = blk_reg;

endmodule : pmcd_top

// *** tb/pmcd_top_properties.sv ***
// Checker of the power mode and clock divider port behaviour
`timescale 1ns/1ns
module pmcd_checker
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Watched inputs
    input wire logic vr_wr_i,
    input wire logic [pmcd_pkg::REGULATOR_FIELD_A_W-1:0] regulator_field_a_i,
    input wire logic div_wr_i,
    input wire logic [pmcd_pkg::PDIV_W-1:0] periph_div_select_i,
    // Watched outputs
    input wire logic [2:0] mode_o,
    input wire logic boot_start_o,
    input wire logic cfg_err_o,
    input wire logic core_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic [pmcd_pkg::PDIV_W-1:0] periph_div_select_o,
    input wire logic regulator_on_o,
    input wire logic [pmcd_pkg::MV_W-1:0] core_supply_mv_o,
    input wire logic pin_hiz_o,
    input wire logic async_block_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    // --------------------------------
    // Sequences
    // --------------------------------
    sequence s_in_deep;
        (mode_o == 3'h3) [*3];
    endsequence
    sequence s_in_active;
        (mode_o == 3'h1) [*3];
    endsequence
    sequence s_hib_req;
        vr_wr_i && regulator_field_a_i == 2'h0 && mode_o inside {3'h0, 3'h1};
    endsequence

    // --------------------------------
    // Properties
    // --------------------------------
    property p_deep_quiet;
        s_in_deep |-> !core_clk_en_o && !periph_clk_en_o;
    endproperty
    a_deep_quiet: assert property (p_deep_quiet)
        else $error("ticks while in deep sleep");
    property p_async;
        async_block_o == (mode_o == 3'h3);
    endproperty
    a_async: assert property (p_async)
        else $error("async block wrong for mode");
    property p_deep_exit;
        $past(mode_o) == 3'h3 && mode_o != 3'h3 |-> mode_o inside {3'h1, 3'h5};
    endproperty
    a_deep_exit: assert property (p_deep_exit)
        else $error("deep sleep left to wrong mode");
    property p_hib_state;
        mode_o == 3'h4
            |-> pin_hiz_o && !regulator_on_o && core_supply_mv_o == 11'h000;
    endproperty
    a_hib_state: assert property (p_hib_state)
        else $error("hibernate outputs wrong");
    property p_hib_entry;
        s_hib_req |=> mode_o == 3'h4;
    endproperty
    a_hib_entry: assert property (p_hib_entry)
        else $error("regulator off write did not hibernate");
    property p_hib_exit;
        $past(mode_o) == 3'h4 && mode_o != 3'h4 |-> mode_o == 3'h5;
    endproperty
    a_hib_exit: assert property (p_hib_exit)
        else $error("hibernate left without reset");
    property p_boot;
        boot_start_o |-> mode_o == 3'h0 && $past(mode_o) == 3'h5;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot pulse out of place");
    property p_div_refuse;
        div_wr_i && periph_div_select_i == 4'h0
            |=> cfg_err_o && $stable(periph_div_select_o);
    endproperty
    a_div_refuse: assert property (p_div_refuse)
        else $error("zero divide select not refused");
    property p_active_ticks;
        s_in_active |-> core_clk_en_o && periph_clk_en_o;
    endproperty
    a_active_ticks: assert property (p_active_ticks)
        else $error("active mode not at input rate");
endmodule : pmcd_checker

bind pmcd_top pmcd_checker u_pmcd_checker
(
    .ref_clk_i, .resetn_i, .vr_wr_i, .regulator_field_a_i, .div_wr_i,
    .periph_div_select_i, .mode_o, .boot_start_o, .cfg_err_o,
    .core_clk_en_o, .periph_clk_en_o, .periph_div_select_o,
    .regulator_on_o, .core_supply_mv_o, .pin_hiz_o, .async_block_o
);

// *** tb/pmcd_top_tb_top.sv ***
// Testbench for the power mode and clock divider
`timescale 1ns/1ns
module pmcd_top_tb_top;
    // --------------------------------
    // Signals
    // --------------------------------
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ext_resetn_i = 1'b1;
    logic rtc_wake_i = 1'b0, can_wake_i = 1'b0, gp_wake_i = 1'b0;
    logic irq_wake_i = 1'b0, mode_req_i = 1'b0, pll_bypass_i = 1'b0;
    logic vr_wr_i = 1'b0, pll_wr_i = 1'b0, div_wr_i = 1'b0;
    logic [2:0] mode_sel_i = 3'h0;
    logic [1:0] regulator_field_a_i = 2'h3, core_div_select_i = 2'h0;
    logic [3:0] vr_level_i = 4'h9, periph_div_select_i = 4'h5;
    logic [7:0] pll_mult_i = 8'h14;
    logic [2:0] mode_o, wake_cause_o;
    logic proc_reset_o, boot_start_o, cfg_err_o, core_clk_en_o;
    logic periph_clk_en_o, pll_enable_o, pll_bypassed_o;
    logic regulator_on_o, pin_hiz_o, async_block_o, boot_seen;
    logic [7:0] pll_mult_o, pll_mult_pend_o;
    logic [3:0] periph_div_select_o;
    logic [1:0] core_div_select_o, regulator_field_a_o;
    logic [10:0] core_supply_mv_o;
    logic [21:0] rows [4];
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int pc, cc, k;

    pmcd_top u_pmcd_top
    (
        .ref_clk_i, .resetn_i, .ext_resetn_i, .rtc_wake_i, .can_wake_i,
        .gp_wake_i, .irq_wake_i, .mode_req_i, .mode_sel_i, .pll_bypass_i,
        .vr_wr_i, .regulator_field_a_i, .vr_level_i, .pll_wr_i,
        .pll_mult_i, .div_wr_i, .periph_div_select_i, .core_div_select_i,
        .mode_o, .wake_cause_o, .proc_reset_o, .boot_start_o, .cfg_err_o,
        .core_clk_en_o, .periph_clk_en_o, .pll_enable_o, .pll_bypassed_o,
        .pll_mult_o, .pll_mult_pend_o, .periph_div_select_o,
        .core_div_select_o, .regulator_on_o, .regulator_field_a_o,
        .core_supply_mv_o, .pin_hiz_o, .async_block_o
    );

    // --------------------------------
    // Clock and timeout
    // --------------------------------
    initial
    begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 2500)
        begin
            fails++;
            finish_test();
        end
    end

    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // Strobe 0 mode, 1 regulator, 2 multiplier, 3 divider
    task automatic wr(input int s);
        step(1);
        {mode_req_i, vr_wr_i, pll_wr_i, div_wr_i} = 4'h8 >> s;
        step(1);
        {mode_req_i, vr_wr_i, pll_wr_i, div_wr_i} = 4'h0;
    endtask : wr
    task automatic count(input int n);
        pc = 0;
        cc = 0;
        repeat (n)
        begin
            step(1);
            if (periph_clk_en_o === 1'b1) pc++;
            if (core_clk_en_o === 1'b1) cc++;
        end
    endtask : count
    task automatic wait_full();
        boot_seen = 1'b0;
        for (k = 0; k < 60 && mode_o !== 3'h0; k++)
        begin
            step(1);
            if (boot_start_o === 1'b1) boot_seen = 1'b1;
        end
    endtask : wait_full
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // --------------------------------
    // Sequence
    // --------------------------------
    initial
    begin
        rows[0] = {4'h1, 2'h0, 8'h78, 8'h78};
        rows[1] = {4'h6, 2'h1, 8'h14, 8'h3C};
        rows[2] = {4'hA, 2'h2, 8'h0C, 8'h1E};
        rows[3] = {4'hF, 2'h3, 8'h08, 8'h0F};
        step(20);
        resetn_i = 1'b1;
        step(3);
        check("mode", mode_o, 3'h0);
        check("pll on", {pll_enable_o, pll_bypassed_o}, 2'h2);
        check("mult", pll_mult_o, 8'h14);
        check("supply", core_supply_mv_o, 11'h4E2);
        foreach (rows[i])
        begin
            {periph_div_select_i, core_div_select_i} = rows[i][21:16];
            wr(3);
            check("div", {periph_div_select_o, core_div_select_o},
                rows[i][21:16]);
            step(20);
            count(120);
            check("periph ticks", pc, rows[i][15:8]);
            check("core ticks", cc, rows[i][7:0]);
        end
        $display("test ratios done");
        periph_div_select_i = 4'h0;
        wr(3);
        check("div err", cfg_err_o, 1'b1);
        check("pdiv kept", periph_div_select_o, 4'hF);
        pll_mult_i = 8'h81;
        wr(2);
        check("mult err", cfg_err_o, 1'b1);
        pll_mult_i = 8'h80;
        wr(2);
        check("mult pend", pll_mult_pend_o, 8'h80);
        vr_level_i = 4'h3;
        wr(1);
        step(1);
        check("level", {regulator_field_a_o, core_supply_mv_o},
            13'h1BB6);
        mode_sel_i = 3'h4;
        wr(0);
        check("mode err", cfg_err_o, 1'b1);
        $display("test writes done");
        mode_sel_i = 3'h3;
        wr(0);
        check("deep", mode_o, 3'h3);
        check("block", async_block_o, 1'b1);
        {can_wake_i, irq_wake_i, gp_wake_i} = 3'h7;
        step(2);
        count(20);
        check("deep ticks", pc + cc, 0);
        check("deep held", mode_o, 3'h3);
        {can_wake_i, irq_wake_i, gp_wake_i, rtc_wake_i} = 4'h1;
        step(5);
        check("rtc exit", mode_o, 3'h1);
        rtc_wake_i = 1'b0;
        count(20);
        check("active ticks", pc + cc, 40);
        mode_sel_i = 3'h0;
        wr(0);
        check("full on", mode_o, 3'h0);
        check("new mult", pll_mult_o, 8'h80);
        for (int b = 0; b < 2; b++)
        begin
            pll_bypass_i = (b == 1);
            mode_sel_i = 3'h2;
            wr(0);
            check("sleep", mode_o, 3'h2);
            irq_wake_i = 1'b1;
            step(4);
            irq_wake_i = 1'b0;
            check("sleep wake", {mode_o, wake_cause_o}, {3'(b), 3'h5});
        end
        $display("test deep sleep done");
        for (int w = 0; w < 4; w++)
        begin
            regulator_field_a_i = 2'h0;
            wr(1);
            check("hib", mode_o, 3'h4);
            check("hiz", {pin_hiz_o, core_supply_mv_o}, 12'h800);
            {rtc_wake_i, can_wake_i, gp_wake_i} = 3'h4 >> w;
            ext_resetn_i = (w != 3);
            step(4);
            check("wake", {proc_reset_o, mode_o, wake_cause_o},
                {4'hD, ((w == 3) ? 3'h1 : 3'(w + 2))});
            {rtc_wake_i, can_wake_i, gp_wake_i, ext_resetn_i} = 4'h1;
            wait_full();
            check("boot", boot_seen, 1'b1);
        end
        check("mult back", pll_mult_o, 8'h14);
        $display("test hibernate done");
        mode_sel_i = 3'h3;
        wr(0);
        ext_resetn_i = 1'b0;
        step(4);
        check("deep reset", mode_o, 3'h5);
        ext_resetn_i = 1'b1;
        wait_full();
        check("full after", {boot_seen, mode_o}, 4'h8);
        $display("test reset pin done");
        finish_test();
    end
endmodule : pmcd_top_tb_top
